// *** testbench/async_port_zero_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module port_checker (
    // Clock and reset
    input wire logic        mclk,
    input wire logic        rst_n,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Pins
    input wire logic        tx_pin,
    input wire logic        port_irq
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    a_ready_after_setup: assert property (psel && !penable |=> pready && penable)
        else $error("no answer after setup");
    a_ready_single: assert property (pready |=> !pready) else $error("pready held");
    a_ready_cause: assert property (pready |-> $past(psel && !penable)) else $error("pready without setup");
    a_err_with_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
    a_idle_data_zero: assert property (!pready |-> prdata == 32'h0) else $error("stale read data");
    a_data_byte_wide: assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper data set");
    a_start_bit_min: assert property ($fell(tx_pin) |=> !tx_pin) else $error("short start bit");
    a_irq_sw_clear: assert property ($fell(port_irq) |-> $past(psel && penable && pready && pwrite, 2))
        else $error("irq dropped without write");
endmodule // port_checker
bind async_port_zero port_checker i_port_checker (
    .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_pin(tx_pin), .port_irq(port_irq)
);
`default_nettype wire

// *** testbench/serial_peer.sv ***
`timescale 1ns/1ps
`default_nettype none
// Remote serial end; idle line is high
module serial_peer #(
    parameter int BIT_CYCLES = 32
) (
    // Clock
    input  wire logic mclk,
    // Line from the port and back to it
    input  wire logic line_in,
    output var  logic line_out
);
    initial line_out = 1'b1;
    task automatic send(input logic [8:0] bits, input int nbits, input logic stop);
        @(posedge mclk);
        line_out <= 1'b0;
        repeat (BIT_CYCLES) @(posedge mclk);
        for (int i = 0; i < nbits; i++) begin
            line_out <= bits[i];
            repeat (BIT_CYCLES) @(posedge mclk);
        end
        line_out <= stop;
        repeat (BIT_CYCLES) @(posedge mclk);
        line_out <= 1'b1;
    endtask
    task automatic recv(input int nbits, output logic [8:0] bits, output logic ok);
        int n;
        bits = 9'h0;
        n = 0;
        while (line_in !== 1'b0 && n < 4000) begin
            @(posedge mclk);
            n++;
        end
        // Sample in the middle of each bit
        repeat (BIT_CYCLES / 2) @(posedge mclk);
        ok = (line_in === 1'b0);
        for (int i = 0; i < nbits; i++) begin
            repeat (BIT_CYCLES) @(posedge mclk);
            bits[i] = line_in;
        end
        repeat (BIT_CYCLES) @(posedge mclk);
        ok = ok && (line_in === 1'b1);
    endtask
endmodule // serial_peer
`default_nettype wire

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        mclk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic        rx_pin, tx_pin, xosc_pin, timer_external_input, port_irq, ok;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r, r2;
    logic [8:0]  bits;
    logic        e;
    int          fail_count, n_tests, cycles;

    async_port_zero i_async_port_zero (
        .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_pin(rx_pin), .tx_pin(tx_pin), .xosc_pin(xosc_pin),
        .timer_external_input(timer_external_input), .port_irq(port_irq)
    );
    // Reload 0xf0 on the system clock: 16 cycles an overflow, 32 a bit
    serial_peer #(.BIT_CYCLES(32)) i_serial_peer (.mclk(mclk), .line_in(tx_pin), .line_out(rx_pin));

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    // Timer clock pins toggle every second cycle, slow enough for the three-flop sync
    always @(posedge mclk) begin
        if (cycles[0]) begin
            xosc_pin <= ~xosc_pin;
            timer_external_input <= ~timer_external_input;
        end
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            final_report;
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
            fail_count++;
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            $display("CHECK FAILED pready expected 1 seen %b", pready);
            fail_count++;
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(what, x, r & m);
    endtask

    task automatic test_reset;
        rd_chk("control", 12'h000, 32'hffffffff, 32'h40);
        rd_chk("reload", 12'h008, 32'hffffffff, 32'h0);
        rd_chk("timer ctrl", 12'h010, 32'hffffffff, 32'h0);
        apb(1'b0, 12'h014, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, r);
        $display("test_reset done");
    endtask
    task automatic test_sources;
        for (int s = 0; s <= 5; s++) begin
            apb(1'b1, 12'h00c, 32'h0);
            apb(1'b1, 12'h010, {28'h0, 3'(s), 1'b1});
            repeat (100) @(posedge mclk);
            apb(1'b0, 12'h00c, 32'h0);
            chk("timer moved", 32'h1, {31'h0, r[7:0] !== 8'h0});
        end
        apb(1'b1, 12'h010, 32'h0);
        apb(1'b0, 12'h00c, 32'h0);
        r2 = r;
        repeat (50) @(posedge mclk);
        rd_chk("timer stopped", 12'h00c, 32'hff, r2);
        apb(1'b1, 12'h008, 32'hf0);
        apb(1'b1, 12'h010, 32'h1);
        $display("test_sources done");
    endtask
    task automatic test_tx8;
        apb(1'b1, 12'h000, 32'h10);
        apb(1'b1, 12'h004, 32'ha5);
        i_serial_peer.recv(8, bits, ok);
        chk("tx byte", 32'ha5, {23'h0, bits});
        chk("tx framing", 32'h1, {31'h0, ok});
        rd_chk("tx done", 12'h000, 32'h2, 32'h2);
        chk("irq", 32'h1, {31'h0, port_irq});
        rd_chk("data read", 12'h004, 32'hff, 32'h0);
        repeat (50) @(posedge mclk);
        rd_chk("tx done held", 12'h000, 32'h2, 32'h2);
        apb(1'b1, 12'h000, 32'h10);
        repeat (2) @(posedge mclk);
        chk("irq cleared", 32'h0, {31'h0, port_irq});
        $display("test_tx8 done");
    endtask
    task automatic test_rx8;
        i_serial_peer.send(9'h03c, 8, 1'b1);
        repeat (10) @(posedge mclk);
        rd_chk("rx flags", 12'h000, 32'h5, 32'h5);
        rd_chk("rx data", 12'h004, 32'hffffffff, 32'h3c);
        chk("irq", 32'h1, {31'h0, port_irq});
        i_serial_peer.send(9'h077, 8, 1'b1);
        rd_chk("overrun", 12'h004, 32'hff, 32'h3c);
        apb(1'b1, 12'h000, 32'h10);
        fork
            i_serial_peer.send(9'h081, 8, 1'b1);
            begin
                repeat (100) @(posedge mclk);
                rd_chk("old byte", 12'h004, 32'hff, 32'h3c);
            end
        join
        repeat (10) @(posedge mclk);
        rd_chk("new byte", 12'h004, 32'hff, 32'h81);
        apb(1'b1, 12'h000, 32'h30);
        i_serial_peer.send(9'h055, 8, 1'b0);
        repeat (10) @(posedge mclk);
        rd_chk("bad stop", 12'h000, 32'h1, 32'h0);
        $display("test_rx8 done");
    endtask
    task automatic test_mode9;
        apb(1'b1, 12'h000, 32'hb8);
        apb(1'b1, 12'h004, 32'h5a);
        i_serial_peer.recv(9, bits, ok);
        chk("tx ninth", 32'h15a, {23'h0, bits});
        chk("tx9 framing", 32'h1, {31'h0, ok});
        apb(1'b1, 12'h000, 32'hb8);
        i_serial_peer.send(9'h022, 9, 1'b1);
        repeat (10) @(posedge mclk);
        rd_chk("data byte skipped", 12'h000, 32'h1, 32'h0);
        i_serial_peer.send(9'h1c3, 9, 1'b0);
        repeat (10) @(posedge mclk);
        rd_chk("address taken", 12'h000, 32'h5, 32'h5);
        rd_chk("address byte", 12'h004, 32'hff, 32'hc3);
        $display("test_mode9 done");
    endtask

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        {rst_n, psel, penable, pwrite, xosc_pin, timer_external_input} = 6'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        test_reset;
        test_sources;
        test_tx8;
        test_rx8;
        test_mode9;
        final_report;
    end
endmodule // tb_top
`default_nettype wire

// *** verilog/async_port_zero.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "uart_cfg.svh"
module async_port_zero
    import uart_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    // Serial pins
    input  wire logic        rx_pin,
    output var  logic        tx_pin,
    // Timer clock pins
    input  wire logic        xosc_pin,
    input  wire logic        timer_external_input,
    // Interrupt request
    output var  logic        port_irq
);
    import uart_pkg::*;

    logic [7:0] serial_control;
    logic [7:0] serial_data_buffer;
    logic [7:0] timer_reload_value;
    logic [3:0] timer_ctrl;
    logic [7:0] timer_low_count;

    // APB decode
    wire access   = psel && penable;
    wire wr       = access && pwrite;
    wire rd       = access && !pwrite;
    wire hit_ctl  = (paddr == `OFF_CONTROL);
    wire hit_dat  = (paddr == `OFF_DATA);
    wire hit_rld  = (paddr == `OFF_RELOAD);
    wire hit_tmr  = (paddr == `OFF_TIMER);
    wire hit_tctl = (paddr == `OFF_TIMER_CTRL);
    wire mapped   = hit_ctl || hit_dat || hit_rld || hit_tmr || hit_tctl;
    wire wr_ctl   = wr && hit_ctl;
    wire wr_dat   = wr && hit_dat;

    wire mode9                 = serial_control[`CTL_MODE9];
    wire multiproc_check_enable = serial_control[`CTL_MCE];
    wire receive_enable_bit    = serial_control[`CTL_RXEN];
    wire tx_ninth_bit          = serial_control[`CTL_TX9];
    wire transmit_done_flag    = serial_control[`CTL_TXDONE];
    wire receive_done_flag     = serial_control[`CTL_RXDONE];

    // Pin synchronisers
    wire rx_level;
    wire xosc_rise;
    wire ext_rise;
    pin_sync u_rx_sync (
        .mclk  (mclk),
        .rst_n (rst_n),
        .pin   (rx_pin),
        .level (rx_level),
        .rise  ()
    );
    pin_sync u_xosc_sync (
        .mclk  (mclk),
        .rst_n (rst_n),
        .pin   (xosc_pin),
        .level (),
        .rise  (xosc_rise)
    );
    pin_sync u_ext_sync (
        .mclk  (mclk),
        .rst_n (rst_n),
        .pin   (timer_external_input),
        .level (),
        .rise  (ext_rise)
    );

    // Receive start edge detection
    logic      rx_prev;
    rx_state_t rx_state;
    wire rx_fall    = rx_prev && !rx_level;
    wire rx_restart = rx_fall && (rx_state == RX_IDLE) && receive_enable_bit;

    wire tx_ovf;
    wire rx_ovf;
    baud_timer u_timer (
        .mclk       (mclk),
        .rst_n      (rst_n),
        .run        (timer_ctrl[`TCTL_RUN]),
        .src        (clk_src_t'(timer_ctrl[`TCTL_SRC_HI:`TCTL_SRC_LO])),
        .reload     (timer_reload_value),
        .xosc_rise  (xosc_rise),
        .ext_rise   (ext_rise),
        .rx_restart (rx_restart),
        .low_wr     (wr && hit_tmr),
        .low_wdata  (pwdata[7:0]),
        .low_count  (timer_low_count),
        .tx_ovf     (tx_ovf),
        .rx_ovf     (rx_ovf)
    );

    // Transmit: bit tick is every second overflow
    logic       tx_half;
    logic       tx_busy;
    logic [9:0] tx_shift;
    logic [3:0] tx_bits;
    // Bit times from the load to the end of the stop bit, start bit included
    function automatic logic [3:0] frame_len(input logic nine);
        return nine ? `TX_FRAME9 : `TX_FRAME8;
    endfunction
    wire tx_tick = tx_ovf && tx_half;
    // One bit time left means the stop bit is being launched, in either frame size
    wire tx_done_evt = tx_busy && tx_tick && (tx_bits == `TX_STOP_LEFT);

    // Halving runs free: a new frame waits for the next bit boundary, up to one bit time
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tx_half <= 1'b0;
        end else if (tx_ovf) begin
            tx_half <= !tx_half;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tx_busy  <= 1'b0;
            tx_shift <= 10'h3ff;
            tx_bits  <= 4'h0;
            tx_pin   <= 1'b1;
        end else begin
            if (wr_dat) begin
                tx_busy  <= 1'b1;
                tx_shift <= {1'b1, (mode9 ? tx_ninth_bit : 1'b1), pwdata[7:0]};
                tx_bits  <= frame_len(mode9);
                tx_pin   <= 1'b1;
            end else if (tx_busy && tx_tick) begin
                if (tx_bits == 4'd0) begin
                    tx_busy <= 1'b0;
                    tx_pin  <= 1'b1;
                end else if (tx_bits == frame_len(mode9)) begin
                    tx_pin  <= 1'b0;
                    tx_bits <= tx_bits - 4'd1;
                end else begin
                    tx_pin   <= tx_shift[0];
                    tx_shift <= {1'b1, tx_shift[9:1]};
                    tx_bits  <= tx_bits - 4'd1;
                end
            end
        end
    end

    // Receive: sample at mid-bit on the receive timer
    logic [1:0] rx_phase;
    logic [3:0] rx_bits;
    logic [8:0] rx_shift;
    wire rx_sample = rx_ovf && (rx_phase == `OVF_MID_BIT);
    wire rx_last   = mode9 ? (rx_bits == `RX_LAST9) : (rx_bits == `RX_LAST8);
    // Eight shifts leave the byte at the top; nine leave the ninth bit above it
    wire [7:0] rx_byte  = mode9 ? rx_shift[7:0] : rx_shift[8:1];
    wire rx_bit9 = mode9 ? rx_shift[8] : rx_level;
    wire rx_accept = (rx_state == RX_STOP) && rx_sample &&
                     !receive_done_flag && (!multiproc_check_enable || rx_bit9);
    rx_state_t next_rx_state;
    always_comb begin
        next_rx_state = rx_state;
        case (rx_state)
            RX_IDLE:  next_rx_state = rx_restart ? RX_START : RX_IDLE;
            RX_START: if (rx_sample) next_rx_state = rx_level ? RX_IDLE : RX_DATA;
            RX_DATA:  if (rx_sample && rx_last) next_rx_state = RX_STOP;
            RX_STOP:  if (rx_sample) next_rx_state = RX_IDLE;
            default:  next_rx_state = RX_IDLE;
        endcase
    end
    // Edge history resets to the idle level, so leaving reset makes no false start
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rx_prev  <= 1'b1;
            rx_state <= RX_IDLE;
        end else begin
            rx_prev  <= rx_level;
            rx_state <= next_rx_state;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rx_phase <= 2'h0;
            rx_bits  <= 4'h0;
            rx_shift <= 9'h000;
        end else begin
            // Restart parks the phase at mid-bit: the first overflow, half a bit in, samples
            if (rx_restart) begin
                rx_phase <= `OVF_MID_BIT;
                rx_bits  <= 4'h0;
            end else if (rx_ovf) begin
                rx_phase <= (rx_phase == `OVF_PER_BIT - 2'd1) ? 2'h0 : rx_phase + 2'd1;
            end
            if (rx_sample && rx_state == RX_DATA) begin
                rx_shift <= {rx_level, rx_shift[8:1]};
                rx_bits  <= rx_bits + 4'd1;
            end
        end
    end

    // Control register; hardware sets win over a simultaneous software clear
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            serial_control <= `CONTROL_RESET;
        end else begin
            if (wr_ctl) begin
                serial_control <= pwdata[7:0] | 8'h40;
            end
            if (tx_done_evt) begin
                serial_control[`CTL_TXDONE] <= 1'b1;
            end
            if (rx_accept) begin
                serial_control[`CTL_RX9]    <= rx_bit9;
                serial_control[`CTL_RXDONE] <= 1'b1;
            end
        end
    end

    // Receive buffer; a byte arriving while the flag is set is lost, the old one kept
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            serial_data_buffer <= `DATA_RESET;
        end else if (rx_accept) begin
            serial_data_buffer <= rx_byte;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            timer_reload_value <= `RELOAD_RESET;
        end else if (wr && hit_rld) begin
            timer_reload_value <= pwdata[7:0];
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            timer_ctrl <= `TCTL_RESET;
        end else if (wr && hit_tctl) begin
            timer_ctrl <= pwdata[3:0];
        end
    end

    // Read mux and answer; zero wait states
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        if (hit_ctl)  rd_mux = serial_control;
        if (hit_dat)  rd_mux = serial_data_buffer;
        if (hit_rld)  rd_mux = timer_reload_value;
        if (hit_tmr)  rd_mux = timer_low_count;
        if (hit_tctl) rd_mux = {4'h0, timer_ctrl};
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            prdata   <= 32'h0000_0000;
            pready   <= 1'b0;
            pslverr  <= 1'b0;
            port_irq <= 1'b0;
        end else begin
            pready   <= psel && !penable;
            pslverr  <= psel && !penable && !mapped;
            prdata   <= (psel && !penable && !pwrite) ? {24'h000000, rd_mux} : 32'h0000_0000;
            port_irq <= serial_control[`CTL_TXDONE] | serial_control[`CTL_RXDONE];
        end
    end
endmodule // async_port_zero
`default_nettype wire

// *** verilog/baud_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "uart_cfg.svh"
// 8-bit auto-reload baud timer with a hidden receive copy
module baud_timer
    import uart_pkg::*;
(
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             rst_n,
    // Control
    input  wire logic             run,
    input  wire uart_pkg::clk_src_t src,
    input  wire logic [7:0]       reload,
    input  wire logic             xosc_rise,
    input  wire logic             ext_rise,
    input  wire logic             rx_restart,
    input  wire logic             low_wr,
    input  wire logic [7:0]       low_wdata,
    // Results
    output var  logic [7:0]       low_count,
    output var  logic             tx_ovf,
    output var  logic             rx_ovf
);
    logic [5:0] pre;
    logic [2:0] xdiv;
    logic [7:0] rx_count;
    wire pre_wrap = (pre == `DIV_48 - 6'd1);
    wire tick_div4  = (pre[1:0] == 2'h3);
    wire tick_div12 = (pre == 6'd11) || (pre == 6'd23) || (pre == 6'd35) || pre_wrap;
    wire xdiv_tick  = xosc_rise && (xdiv == 3'h7);
    logic tick;
    always_comb begin
        case (src)
            SRC_SYSTEM_CLOCK: tick = 1'b1;
            SRC_DIV4:   tick = tick_div4;
            SRC_DIV12:  tick = tick_div12;
            SRC_DIV48:  tick = pre_wrap;
            SRC_XDIV8:  tick = xdiv_tick;
            SRC_EXT:    tick = ext_rise;
            default:    tick = 1'b0;
        endcase
    end
    wire cnt_en = run && tick;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pre       <= 6'h00;
            xdiv      <= 3'h0;
            low_count <= 8'h00;
            rx_count  <= 8'h00;
            tx_ovf    <= 1'b0;
            rx_ovf    <= 1'b0;
        end else begin
            pre    <= pre_wrap ? 6'h00 : pre + 6'd1;
            xdiv   <= xosc_rise ? xdiv + 3'd1 : xdiv;
            tx_ovf <= cnt_en && (low_count == 8'hff);
            rx_ovf <= cnt_en && (rx_count == 8'hff) && !rx_restart;
            if (low_wr) begin
                low_count <= low_wdata;
            end else if (cnt_en) begin
                low_count <= (low_count == 8'hff) ? reload : low_count + 8'd1;
            end
            if (rx_restart) begin
                rx_count <= reload;
            end else if (cnt_en) begin
                rx_count <= (rx_count == 8'hff) ? reload : rx_count + 8'd1;
            end
        end
    end
endmodule // baud_timer
`default_nettype wire

// *** verilog/pin_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
// Three-stage synchroniser; output changes once stages two and three agree
module pin_sync (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic rst_n,
    // Pin
    input  wire logic pin,
    output var  logic level,
    output var  logic rise
);
    logic s1;
    logic s2;
    logic s3;
    wire  agree = (s2 == s3);
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s1    <= 1'b1;
            s2    <= 1'b1;
            s3    <= 1'b1;
            level <= 1'b1;
            rise  <= 1'b0;
        end else begin
            s1    <= pin;
            s2    <= s1;
            s3    <= s2;
            rise  <= agree && s3 && !level;
            if (agree) begin
                level <= s3;
            end
        end
    end
endmodule // pin_sync
`default_nettype wire

// *** verilog/uart_cfg.svh ***
`ifndef UART_CFG_SVH
`define UART_CFG_SVH
// Register byte offsets
`define OFF_CONTROL     12'h000
`define OFF_DATA        12'h004
`define OFF_RELOAD      12'h008
`define OFF_TIMER       12'h00c
`define OFF_TIMER_CTRL  12'h010
// Control register field positions
`define CTL_RXDONE      0
`define CTL_TXDONE      1
`define CTL_RX9         2
`define CTL_TX9         3
`define CTL_RXEN        4
`define CTL_MCE         5
`define CTL_ONE         6
`define CTL_MODE9       7
// Timer control field positions
`define TCTL_RUN        0
`define TCTL_SRC_LO     1
`define TCTL_SRC_HI     3
// Reset values
`define CONTROL_RESET   8'h40
`define RELOAD_RESET    8'h00
`define TCTL_RESET      4'h0
`define DATA_RESET      8'h00
// Prescale divide counts
`define DIV_4           6'd4
`define DIV_8           6'd8
`define DIV_12          6'd12
`define DIV_48          6'd48
// Receive oversampling: timer overflows per bit, and the mid-bit point
`define OVF_PER_BIT     2'd2
`define OVF_MID_BIT     2'd1
// Transmit frame lengths in bit times, start bit included, and bit times left at the stop bit
`define TX_FRAME8       4'd10
`define TX_FRAME9       4'd11
`define TX_STOP_LEFT    4'd1
// Receive: index of the last data bit shifted in
`define RX_LAST8        4'd7
`define RX_LAST9        4'd8
`endif

// *** verilog/uart_pkg.sv ***
package uart_pkg;
    typedef enum logic [2:0] {
        SRC_SYSTEM_CLOCK = 3'h0,
        SRC_DIV4   = 3'h1,
        SRC_DIV12  = 3'h2,
        SRC_DIV48  = 3'h3,
        SRC_XDIV8  = 3'h4,
        SRC_EXT    = 3'h5
    } clk_src_t;
    typedef enum logic [3:0] {
        RX_IDLE  = 4'b0001,
        RX_START = 4'b0010,
        RX_DATA  = 4'b0100,
        RX_STOP  = 4'b1000
    } rx_state_t;
endpackage
